// ===== rtl/ctb_consts.vh
// Constants for the capture/compare time base block
`ifndef CTB_CONSTS_VH
`define CTB_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CTB_OFF_CONTROL   12'h000
`define CTB_OFF_TIMER_A   12'h004
`define CTB_OFF_TIMER_B   12'h008
`define CTB_OFF_RELOAD_A  12'h00c
`define CTB_OFF_RELOAD_B  12'h010
`define CTB_OFF_FLAGS     12'h014

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define CTB_SEL_A_LSB     0
`define CTB_MODE_A_BIT    3
`define CTB_RUN_A_BIT     6
`define CTB_SEL_B_LSB     8
`define CTB_MODE_B_BIT    11
`define CTB_RUN_B_BIT     14
`define CTB_CONTROL_MASK  16'h4f4f
`define CTB_CONTROL_RESET 16'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
// One system-clock cycle is one state; base prescale is 8 states (16 osc periods)
`define CTB_BASE_STATES   8
`define CTB_PRESCALE_W    11

`endif

// ===== rtl/ctb_time_base.v
// Two 16-bit up-counting time bases with reload, prescaler and counter mode, APB slave
`timescale 1ns/1ps
`include "ctb_consts.vh"

module ctb_time_base #(
  parameter PRESCALE_W = `CTB_PRESCALE_W
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // External count pin and companion timer event
  input  wire        ext_count_pin,
  input  wire        companion_timer_event,
  // Interrupt requests
  output wire        irq_a,
  output wire        irq_b
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [15:0]           time_base_control;
  reg  [15:0]           timer_a;
  reg  [15:0]           timer_b;
  reg  [15:0]           reload_a;
  reg  [15:0]           reload_b;
  reg                   overflow_flag_a;
  reg                   overflow_flag_b;
  reg                   irq_enable_a;
  reg                   irq_enable_b;
  reg  [PRESCALE_W-1:0] prescale;
  reg                   pin_meta;
  reg                   pin_sync;
  reg                   pin_last;
  reg                   comp_last;
  reg                   tick_b_late;

  wire                  wr_en = psel & penable & pwrite;
  wire                  addr_ok;

  wire [2:0] input_select_a = time_base_control[`CTB_SEL_A_LSB+2:`CTB_SEL_A_LSB];
  wire [2:0] input_select_b = time_base_control[`CTB_SEL_B_LSB+2:`CTB_SEL_B_LSB];
  wire       mode_bit_a     = time_base_control[`CTB_MODE_A_BIT];
  wire       mode_bit_b     = time_base_control[`CTB_MODE_B_BIT];
  wire       run_bit_a      = time_base_control[`CTB_RUN_A_BIT];
  wire       run_bit_b      = time_base_control[`CTB_RUN_B_BIT];

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign addr_ok = (paddr == `CTB_OFF_CONTROL) | (paddr == `CTB_OFF_TIMER_A) |
                   (paddr == `CTB_OFF_TIMER_B) | (paddr == `CTB_OFF_RELOAD_A) |
                   (paddr == `CTB_OFF_RELOAD_B) | (paddr == `CTB_OFF_FLAGS);

  // ------------------------------------------------------------
  // Prescaler and event detection
  // ------------------------------------------------------------
  // A free-running divider: a run bit set mid-interval sees its first tick within one interval
  always @(posedge clock) begin
    if (rst) begin
      prescale    <= {PRESCALE_W{1'b0}};
      pin_meta    <= 1'b0;
      pin_sync    <= 1'b0;
      pin_last    <= 1'b0;
      comp_last   <= 1'b0;
    end else begin
      prescale    <= prescale + 1'b1;
      pin_meta    <= ext_count_pin;
      pin_sync    <= pin_meta;
      pin_last    <= pin_sync;
      comp_last   <= companion_timer_event;
    end
  end

  // Tick when all low bits of the divider are ones; 8 states times 2^select
  function tick_of;
    input [PRESCALE_W-1:0] cnt;
    input [2:0]            sel;
    reg   [PRESCALE_W-1:0] mask;
    begin
      mask    = ({{(PRESCALE_W-1){1'b0}}, 1'b1} << ({1'b0, sel} + 4'd3)) - 1'b1;
      tick_of = ((cnt & mask) == mask);
    end
  endfunction

  wire pin_rise  = pin_sync & ~pin_last;
  wire pin_fall  = ~pin_sync & pin_last;
  wire comp_rise = companion_timer_event & ~comp_last;

  reg  inc_a;
  reg  inc_b_now;
  always @* begin
    if (!mode_bit_a)
      inc_a = tick_of(prescale, input_select_a);
    else begin
      case (input_select_a[1:0])
        2'b00:   inc_a = comp_rise;
        2'b01:   inc_a = pin_rise;
        2'b10:   inc_a = pin_fall;
        default: inc_a = pin_rise | pin_fall;
      endcase
    end
    inc_a = inc_a & run_bit_a;
    if (!mode_bit_b)
      inc_b_now = tick_of(prescale, input_select_b);
    else
      inc_b_now = (input_select_b[1:0] == 2'b00) & comp_rise;
    inc_b_now = inc_b_now & run_bit_b;
  end

  // Timer B always serviced one state after its due event, so it trails timer A
  always @(posedge clock) begin
    if (rst)
      tick_b_late <= 1'b0;
    else
      tick_b_late <= inc_b_now;
  end

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  wire wr_ctl   = wr_en & (paddr == `CTB_OFF_CONTROL);
  wire wr_ta    = wr_en & (paddr == `CTB_OFF_TIMER_A);
  wire wr_tb    = wr_en & (paddr == `CTB_OFF_TIMER_B);
  wire wr_ra    = wr_en & (paddr == `CTB_OFF_RELOAD_A);
  wire wr_rb    = wr_en & (paddr == `CTB_OFF_RELOAD_B);
  wire wr_fl    = wr_en & (paddr == `CTB_OFF_FLAGS);
  wire rd_setup = psel & ~penable & ~pwrite;

  // ------------------------------------------------------------
  // Overflow detection
  // ------------------------------------------------------------
  // A CPU write in the same state cancels the reload, so that overflow raises no flag
  wire ovf_a = inc_a & (timer_a == 16'hffff) & ~wr_ta;
  wire ovf_b = tick_b_late & (timer_b == 16'hffff) & ~wr_tb;

  // ------------------------------------------------------------
  // Control and reload registers
  // ------------------------------------------------------------
  reg  [15:0] next_control;
  reg  [15:0] next_reload_a;
  reg  [15:0] next_reload_b;
  always @* begin
    next_control  = time_base_control;
    next_reload_a = reload_a;
    next_reload_b = reload_b;
    if (wr_ctl)
      next_control = pwdata[15:0] & `CTB_CONTROL_MASK;
    if (wr_ra)
      next_reload_a = pwdata[15:0];
    if (wr_rb)
      next_reload_b = pwdata[15:0];
  end

  always @(posedge clock) begin
    if (rst) begin
      time_base_control <= `CTB_CONTROL_RESET;
      reload_a          <= 16'h0000;
      reload_b          <= 16'h0000;
    end else begin
      time_base_control <= next_control;
      reload_a          <= next_reload_a;
      reload_b          <= next_reload_b;
    end
  end

  // ------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------
  reg  [15:0] next_timer_a;
  reg  [15:0] next_timer_b;
  // Priority: CPU write, then reload on overflow, then plain increment
  always @* begin
    next_timer_a = timer_a;
    if (wr_ta)
      next_timer_a = pwdata[15:0];
    else if (ovf_a)
      next_timer_a = reload_a;
    else if (inc_a)
      next_timer_a = timer_a + 16'h0001;
  end

  always @* begin
    next_timer_b = timer_b;
    if (wr_tb)
      next_timer_b = pwdata[15:0];
    else if (ovf_b)
      next_timer_b = reload_b;
    else if (tick_b_late)
      next_timer_b = timer_b + 16'h0001;
  end

  always @(posedge clock) begin
    if (rst) begin
      timer_a <= 16'h0000;
      timer_b <= 16'h0000;
    end else begin
      timer_a <= next_timer_a;
      timer_b <= next_timer_b;
    end
  end

  // ------------------------------------------------------------
  // Overflow flags and request enables
  // ------------------------------------------------------------
  reg         next_flag_a;
  reg         next_flag_b;
  reg         next_enable_a;
  reg         next_enable_b;
  // Write one clears a flag, but an overflow in the same state keeps it set
  always @* begin
    next_enable_a = irq_enable_a;
    next_enable_b = irq_enable_b;
    next_flag_a   = overflow_flag_a;
    next_flag_b   = overflow_flag_b;
    if (wr_fl) begin
      next_enable_a = pwdata[2];
      next_enable_b = pwdata[3];
      if (pwdata[0])
        next_flag_a = 1'b0;
      if (pwdata[1])
        next_flag_b = 1'b0;
    end
    if (ovf_a)
      next_flag_a = 1'b1;
    if (ovf_b)
      next_flag_b = 1'b1;
  end

  always @(posedge clock) begin
    if (rst) begin
      irq_enable_a    <= 1'b0;
      irq_enable_b    <= 1'b0;
      overflow_flag_a <= 1'b0;
      overflow_flag_b <= 1'b0;
    end else begin
      irq_enable_a    <= next_enable_a;
      irq_enable_b    <= next_enable_b;
      overflow_flag_a <= next_flag_a;
      overflow_flag_b <= next_flag_b;
    end
  end

  // Requests only reach the CPU while enabled; the flag itself stays readable
  assign irq_a = overflow_flag_a & irq_enable_a;
  assign irq_b = overflow_flag_b & irq_enable_b;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  reg  [31:0] next_prdata;
  // Captured in the setup cycle so that the access phase needs no wait state
  always @* begin
    next_prdata = prdata;
    if (rd_setup) begin
      case (paddr)
        `CTB_OFF_CONTROL:  next_prdata = {16'h0000, time_base_control};
        `CTB_OFF_TIMER_A:  next_prdata = {16'h0000, timer_a};
        `CTB_OFF_TIMER_B:  next_prdata = {16'h0000, timer_b};
        `CTB_OFF_RELOAD_A: next_prdata = {16'h0000, reload_a};
        `CTB_OFF_RELOAD_B: next_prdata = {16'h0000, reload_b};
        `CTB_OFF_FLAGS:    next_prdata = {28'h0000000, irq_enable_b, irq_enable_a,
                                          overflow_flag_b, overflow_flag_a};
        default:           next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clock) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else
      prdata <= next_prdata;
  end

endmodule // ctb_time_base

// ===== tb/ctb_chk.sv
// Port checker for the time base block
`timescale 1ns/1ps
module ctb_chk (
  // Clock and reset
  input wire        clock,
  input wire        rst,
  // Register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Requests
  input wire        irq_a,
  input wire        irq_b
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd_setup = psel && !penable && !pwrite;
  wire hole     = (paddr > 12'h014) || (paddr[1:0] != 2'b00);
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("no ready in access");
  a_err_unmapped: assert property (psel && penable && hole |-> pslverr)
    else $error("no error on hole");
  a_err_mapped: assert property (!hole |-> !pslverr)
    else $error("error on mapped place");
  a_reset_clear: assert property ($past(rst) |-> !irq_a && !irq_b && prdata == 32'h0)
    else $error("not clear after reset");
  a_upper_zero: assert property (rd_setup |=> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_ctrl_mask: assert property (rd_setup && paddr == 12'h000 |=> (prdata & ~32'h4f4f) == 32'h0)
    else $error("reserved control bit set");
  a_hole_zero: assert property (rd_setup && hole |=> prdata == 32'h0)
    else $error("hole read not zero");
  a_rdata_hold: assert property (!rd_setup |=> $stable(prdata))
    else $error("read data moved");
  c_irq_a: cover property ($rose(irq_a));
  c_irq_b: cover property ($rose(irq_b));
  c_err: cover property (pslverr);
endmodule // ctb_chk

bind ctb_time_base ctb_chk u_chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_a(irq_a), .irq_b(irq_b));

// ===== tb/ctb_far_model.sv
// Far-side model: external count pin and companion timer events
`timescale 1ns/1ps
module ctb_far_model (
  // Clock
  input wire   clock,
  // Count sources
  output logic ext_count_pin,
  output logic companion_timer_event
);
  initial begin
    ext_count_pin = 1'b0;
    companion_timer_event = 1'b0;
  end
  // Ten states each side of a change, above the eight-state minimum
  task automatic pin_edge();
    repeat (10) @(posedge clock);
    ext_count_pin <= ~ext_count_pin;
    repeat (10) @(posedge clock);
  endtask
  task automatic comp_event();
    @(posedge clock);
    companion_timer_event <= 1'b1;
    repeat (3) @(posedge clock);
    companion_timer_event <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
endmodule // ctb_far_model

// ===== tb/testbench.sv
// Self-checking bench for the time base block
`timescale 1ns/1ps
module testbench;
  logic        clock, rst, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] v, a1, b1;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin, comp, irq_a, irq_b;
  wire  [1:0]  irq = {irq_b, irq_a};
  int          fail_count, compares, s, c, i, n;
  integer      seed;
  ctb_time_base DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(pin), .companion_timer_event(comp), .irq_a(irq_a), .irq_b(irq_b));
  ctb_far_model FAR (.clock(clock), .ext_count_pin(pin), .companion_timer_event(comp));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [15:0] cnt_exp(int code, bit tb);
    return tb ? (code == 0 ? 16'h2 : 16'h0) : (code == 3 ? 16'h4 : 16'h2);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    seed = 32'hf91f08ec;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'hffffffff);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h4f4f);
    for (i = 0; i < 2; i++) begin
      v = 16'($random(seed));
      apb(1'b1, 12'(12 + i * 4), {16'hffff, v});
      apb(1'b0, 12'(12 + i * 4), 32'h0);
      chk(rd, {16'h0, v});
    end
    // Two reads before and after two intervals less one state, for every prescale code
    for (s = 0; s < 8; s++) begin
      v = 16'($random(seed)) & 16'h7fff;
      apb(1'b1, 12'h004, {16'h0, v});
      apb(1'b1, 12'h008, {16'h0, v});
      apb(1'b1, 12'h000, 32'h4040 | s | (s << 8));
      apb(1'b0, 12'h004, 32'h0);
      a1 = rd[15:0];
      apb(1'b0, 12'h008, 32'h0);
      b1 = rd[15:0];
      repeat ((16 << s) - 7) @(posedge clock);
      apb(1'b0, 12'h004, 32'h0);
      chk(16'(rd[15:0] - a1), 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      chk(16'(rd[15:0] - b1), 32'h2);
    end
    for (i = 0; i < 2; i++) begin
      v = 16'($random(seed));
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'(12 + i * 4), {16'h0, v});
      apb(1'b1, 12'(4 + i * 4), 32'hffff);
      apb(1'b1, 12'h014, 32'h4 << i);
      apb(1'b1, 12'h000, 32'h0040 << (i * 8));
      for (n = 0; n < 40 && irq[i] !== 1'b1; n++) @(posedge clock);
      chk({31'h0, irq[i]}, 32'h1);
      apb(1'b0, 12'(4 + i * 4), 32'h0);
      chk(rd, {16'h0, v});
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h014, 32'h5 << i);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h4 << i);
      chk({31'h0, irq[i]}, 32'h0);
    end
    for (c = 0; c < 4; c++) begin
      apb(1'b1, 12'h000, 32'h4848 | c | (c << 8));
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h0);
      repeat (4) FAR.pin_edge();
      repeat (2) FAR.comp_event();
      repeat (10) @(posedge clock);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {16'h0, cnt_exp(c, 1'b0)});
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, {16'h0, cnt_exp(c, 1'b1)});
    end
    conclude();
  end
endmodule // testbench
